//--- rtl/nsu_pkg.sv
// Shared constants and types for the navigation sentence serial output block
package nsu_pkg;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int FIX_BLINK_MS = 1000;
  localparam int FIX_BLINK_CYCLES = (CLK_HZ / 1000) * FIX_BLINK_MS;
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int MAX_SENTENCE_CHARS = 80;
  localparam int FIFO_DEPTH = 16;
  localparam int MIN_CN0_DBHZ = 30;
  // ==========================================
  // Characters
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_A_UP = 8'h41;
  localparam logic [3:0] HEX_TEN = 4'ha;
  // ==========================================
  // Fix quality codes
  localparam logic [7:0] FIXQ_INVALID = 8'h30;
  localparam logic [7:0] FIXQ_SAT = 8'h31;
  localparam logic [7:0] FIXQ_PROP = 8'h36;
  // ==========================================
  // Sentence kinds in periodic order
  typedef enum logic [3:0]
  {
    NSU_INTRO, NSU_GGA, NSU_GSA, NSU_GLL, NSU_RMC, NSU_VTG, NSU_GSV, NSU_OPOS, NSU_OVEL
  } nsu_kind_e;
  // Fix status pin modes
  typedef enum logic [1:0]
  {
    NSU_FS_NONE, NSU_FS_TRACK, NSU_FS_FIX
  } nsu_fs_e;
endpackage

//--- rtl/nsu_stream_if.sv
// Byte stream carrier between the framer, the FIFO and the serialiser
`timescale 1ns/100ps
interface nsu_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src
  (
    output valid,
    output data,
    input ready
  );
  modport snk
  (
    input valid,
    input data,
    output ready
  );
endinterface

//--- rtl/nsu_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module nsu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  nsu_stream_if.snk wr,
  nsu_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire push = ce && wr.valid && wr.ready;
  wire pop = ce && rd.valid && rd.ready;
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("nsu_fifo: depth must be a power of two of at least 2");
  end
  // Full and empty come from the count, so both are exact
  assign wr.ready = (count != DEPTH[AW:0]);
  assign rd.valid = (count != '0);
  assign rd.data = mem[rptr];
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wptr <= wptr + 1'b1;
      if (pop)
        rptr <= rptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
  // Storage carries no reset, it is only read behind valid
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr] <= wr.data;
  end
  property p_no_overflow;
    @(posedge clk) disable iff (!rstn) count <= DEPTH[AW:0];
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo count over depth");
endmodule

//--- rtl/nsu_uart_tx.sv
// Serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/100ps
module nsu_uart_tx
  import nsu_pkg::*;
#(
  parameter int BIT_CYC = nsu_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  nsu_stream_if.snk in,
  output logic txd,
  output logic busy
);
  logic [$clog2(BIT_CYC)-1:0] baud_cnt;
  logic [3:0] bit_idx;
  logic [9:0] shreg;
  initial
  begin
    if (BIT_CYC < 2)
      $error("nsu_uart_tx: bit time too short");
  end
  wire bit_end = (baud_cnt == ($clog2(BIT_CYC))'(BIT_CYC - 1));
  wire last_bit = (bit_idx == 4'(DATA_BITS + STOP_BITS));
  assign in.ready = ce && !busy;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      baud_cnt <= '0;
      bit_idx <= '0;
      shreg <= '1;
      txd <= 1'b1;
    end
    else if (ce)
    begin
      if (!busy && in.valid)
      begin
        shreg <= {1'b1, in.data, 1'b0};
        busy <= 1'b1;
        baud_cnt <= '0;
        bit_idx <= '0;
        txd <= 1'b0;
      end
      else if (busy)
      begin
        if (bit_end)
        begin
          baud_cnt <= '0;
          bit_idx <= bit_idx + 4'd1;
          shreg <= {1'b1, shreg[9:1]};
          txd <= last_bit ? 1'b1 : shreg[1];
          busy <= !last_bit;
        end
        else
          baud_cnt <= baud_cnt + 1'b1;
      end
    end
  end
  property p_idle_high;
    @(posedge clk) disable iff (!rstn) !busy |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
  // start bit is low in the cycle busy rises
  property p_start_bit;
    @(posedge clk) disable iff (!rstn)
      $rose(busy) && ce |-> !txd;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");
endmodule

//--- rtl/nsu_top.sv
// Navigation sentence framer with serial output and status pins
`timescale 1ns/100ps
module nsu_top
  import nsu_pkg::*;
#(
  parameter int BLINK_CYC = nsu_pkg::FIX_BLINK_CYCLES,
  parameter int BIT_CYC = nsu_pkg::BIT_CYCLES,
  parameter int FDEPTH = nsu_pkg::FIFO_DEPTH,
  parameter int FIELD_CHARS = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic epoch_tick,
  input wire logic any_tracked,
  input wire logic fix_valid,
  input wire logic fix_propagated,
  input wire logic [7:0] min_cn0_dbhz,
  input wire logic utc_ready,
  input wire logic subframe_seen,
  input wire logic [FIELD_CHARS*8-1:0] field_text,
  input wire logic [3:0] field_len,
  output logic field_req,
  output logic [3:0] field_sel,
  output logic txd,
  output logic fix_status_output,
  output logic epoch_out,
  output logic time_refined
);
  import nsu_pkg::*;
  initial
  begin
    if (FIELD_CHARS < 1 || FIELD_CHARS > 15 || BLINK_CYC < 1)
      $error("nsu_top: field width out of range");
  end
  // ==========================================
  // Pin synchronisers (status inputs are asynchronous)
  logic [1:0] s_trk, s_fix, s_prop, s_utc, s_sub, s_ep;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_trk <= '0;
      s_fix <= '0;
      s_prop <= '0;
      s_utc <= '0;
      s_sub <= '0;
      s_ep <= '0;
    end
    else if (ce)
    begin
      s_trk <= {s_trk[0], any_tracked};
      s_fix <= {s_fix[0], fix_valid};
      s_prop <= {s_prop[0], fix_propagated};
      s_utc <= {s_utc[0], utc_ready};
      s_sub <= {s_sub[0], subframe_seen};
      s_ep <= {s_ep[0], epoch_tick};
    end
  end
  wire trk = s_trk[1];
  wire prop = s_prop[1];
  wire cn0_ok = (min_cn0_dbhz >= 8'(MIN_CN0_DBHZ));
  // no position with all signals lost
  wire pos_ok = s_fix[1] && trk && cn0_ok;
  // ==========================================
  // Byte stream: framer -> FIFO -> serialiser
  nsu_stream_if #(.W(8)) fr_s();
  nsu_stream_if #(.W(8)) tx_s();
  nsu_fifo #(.WIDTH(8), .DEPTH(FDEPTH)) u_fifo
  (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .wr(fr_s.snk),
    .rd(tx_s.src)
  );
  logic tx_busy;
  logic txd_i;
  nsu_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx
  (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in(tx_s.snk),
    .txd(txd_i),
    .busy(tx_busy)
  );
  // ==========================================
  // Sentence sequencer
  typedef enum logic [2:0] {ST_DOLLAR, ST_HEAD, ST_FIELD, ST_STAR, ST_HEX, ST_CR, ST_LF}
    nsu_st_e;
  nsu_st_e st;
  nsu_kind_e kind;
  logic [3:0] fidx;
  logic [3:0] cidx;
  logic [7:0] csum;
  logic [6:0] len;
  logic started;
  logic hex_lo;
  logic [4:0][7:0] head;
  logic [3:0] nfields;
  // GP talker, maker prefix, sentence types
  always_comb
  begin
    head = {CH_G, CH_P, 8'h47, 8'h47, 8'h41};
    nfields = 4'd0;
    unique case (kind)
      NSU_INTRO: begin head = {CH_P, CH_S, 8'h49, 8'h4e, 8'h49}; nfields = 4'd1; end
      NSU_GGA: begin head = {CH_G, CH_P, 8'h47, 8'h47, 8'h41}; nfields = 4'd14; end
      NSU_GSA: begin head = {CH_G, CH_P, 8'h47, 8'h53, 8'h41}; nfields = 4'd8; end
      NSU_GLL: begin head = {CH_G, CH_P, 8'h47, 8'h4c, 8'h4c}; nfields = 4'd7; end
      NSU_RMC: begin head = {CH_G, CH_P, 8'h52, 8'h4d, 8'h43}; nfields = 4'd11; end
      NSU_VTG: begin head = {CH_G, CH_P, 8'h56, 8'h54, 8'h47}; nfields = 4'd9; end
      NSU_GSV: begin head = {CH_G, CH_P, 8'h47, 8'h53, 8'h56}; nfields = 4'd7; end
      NSU_OPOS: begin head = {CH_P, CH_S, 8'h4c, 8'h53, 8'h50}; nfields = 4'd7; end
      NSU_OVEL: begin head = {CH_P, CH_S, 8'h4c, 8'h53, 8'h56}; nfields = 4'd7; end
      default: begin head = {CH_G, CH_P, 8'h47, 8'h47, 8'h41}; nfields = 4'd0; end
    endcase
  end
  // GPS time after sub-frame, fix or not; UTC blank until UTC ready or without a position
  wire is_utc_field = (kind == NSU_GGA && fidx == 4'd0) || (kind == NSU_GLL && fidx == 4'd4)
    || (kind == NSU_RMC && fidx == 4'd0);
  wire is_gps_time = (kind == NSU_OPOS || kind == NSU_OVEL) && fidx == 4'd0;
  wire is_pos_field = (kind != NSU_INTRO && kind != NSU_GSV && kind != NSU_GSA);
  // quality is GGA field 5, after time and both coordinates
  wire is_fixq = (kind == NSU_GGA && fidx == 4'd5);
  wire [7:0] fixq_ch = !pos_ok ? FIXQ_INVALID : (prop ? FIXQ_PROP : FIXQ_SAT);
  wire blank = (is_utc_field && !s_utc[1]) || (is_gps_time && !s_sub[1])
    || (is_pos_field && !pos_ok && !is_fixq && !is_gps_time);
  wire [3:0] flen = blank ? 4'd0 : (is_fixq ? 4'd1 : field_len);
  wire [7:0] field_ch = is_fixq ? fixq_ch : field_text[(cidx - 4'd1)*8 +: 8];
  // stop at 75 so star, hex, CR, LF fit
  wire room = (len < 7'(MAX_SENTENCE_CHARS - 6));
  wire [3:0] nib = hex_lo ? csum[3:0] : csum[7:4];
  wire [7:0] hex_ch = (nib < HEX_TEN) ? CH_ZERO + 8'(nib) : CH_A_UP + 8'(nib - HEX_TEN);
  logic [7:0] out_ch;
  always_comb
  begin
    out_ch = CH_DOLLAR;
    unique case (st)
      ST_DOLLAR: out_ch = CH_DOLLAR;
      ST_HEAD: out_ch = head[4 - cidx];
      ST_FIELD: out_ch = (cidx == 4'd0) ? CH_COMMA : field_ch;
      ST_STAR: out_ch = CH_STAR;
      ST_HEX: out_ch = hex_ch;
      ST_CR: out_ch = CH_CR;
      ST_LF: out_ch = CH_LF;
      default: out_ch = CH_DOLLAR;
    endcase
  end
  logic field_req_d;
  wire fld_ready = (st != ST_FIELD) || (cidx == 4'd0) || field_req_d;
  assign fr_s.valid = ce && fld_ready;
  assign fr_s.data = out_ch;
  wire step = fr_s.valid && fr_s.ready;
  wire fld_done = (cidx == flen) || !room;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= ST_DOLLAR;
      kind <= NSU_INTRO;
      started <= 1'b0;
      fidx <= '0;
      cidx <= '0;
      csum <= '0;
      len <= '0;
      hex_lo <= 1'b0;
      field_req <= 1'b0;
      field_req_d <= 1'b0;
      field_sel <= '0;
    end
    else if (ce)
    begin
      if (step && st == ST_FIELD && cidx == 4'd0)
        field_req_d <= 1'b0;
      else if (field_req)
        field_req_d <= 1'b1;
      field_req <= 1'b0;
      if (step)
      begin
        len <= len + 7'd1;
        if (st == ST_HEAD || st == ST_FIELD)
          csum <= csum ^ out_ch;
        unique case (st)
          ST_DOLLAR: begin st <= ST_HEAD; cidx <= '0; csum <= '0; len <= 7'd1; end
          ST_HEAD:
          begin
            cidx <= cidx + 4'd1;
            if (cidx == 4'd4)
            begin
              st <= (nfields == 4'd0) ? ST_STAR : ST_FIELD;
              cidx <= '0;
              fidx <= '0;
            end
          end
          ST_FIELD:
          begin
            if (cidx == 4'd0)
            begin
              field_sel <= fidx;
              field_req <= 1'b1;
            end
            if (cidx != 4'd0 && fld_done)
            begin
              cidx <= '0;
              fidx <= fidx + 4'd1;
              if (fidx + 4'd1 == nfields || !room)
                st <= ST_STAR;
            end
            else if (cidx == 4'd0 && (blank || !room))
            begin
              fidx <= fidx + 4'd1;
              if (fidx + 4'd1 == nfields || !room)
                st <= ST_STAR;
            end
            else
              cidx <= cidx + 4'd1;
          end
          ST_STAR: begin st <= ST_HEX; hex_lo <= 1'b0; end
          ST_HEX:
          begin
            hex_lo <= 1'b1;
            if (hex_lo)
              st <= ST_CR;
          end
          ST_CR: st <= ST_LF;
          ST_LF:
          begin
            st <= ST_DOLLAR;
            started <= 1'b1;
            kind <= (kind == NSU_OVEL || kind == NSU_INTRO) ? NSU_GGA
              : nsu_kind_e'(kind + 4'd1);
          end
          default: st <= ST_DOLLAR;
        endcase
      end
    end
  end
  // ==========================================
  // Status pins
  logic [$clog2(BLINK_CYC+1)-1:0] blink_cnt;
  logic blink;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
      fix_status_output <= 1'b0;
      epoch_out <= 1'b0;
      time_refined <= 1'b0;
      txd <= 1'b1;
    end
    else if (ce)
    begin
      txd <= txd_i;
      // epoch edge only with a reportable position
      epoch_out <= s_ep[1] && pos_ok;
      if (pos_ok)
        time_refined <= 1'b1;
      else if (!s_sub[1])
        time_refined <= 1'b0;
      // 1 s high, 1 s low while tracking without a position
      if (!trk || pos_ok || blink_cnt == ($bits(blink_cnt))'(BLINK_CYC - 1))
      begin
        blink_cnt <= '0;
        blink <= trk && !pos_ok && !blink;
      end
      else
        blink_cnt <= blink_cnt + 1'b1;
      fix_status_output <= pos_ok ? 1'b1 : (trk ? blink : 1'b0);
    end
  end
  property p_max_len;
    @(posedge clk) disable iff (!rstn) len <= 7'(MAX_SENTENCE_CHARS);
  endproperty
  a_max_len: assert property (p_max_len) else $error("sentence over length");
  property p_fix_high;
    @(posedge clk) disable iff (!rstn) ce && pos_ok |=> fix_status_output;
  endproperty
  a_fix_high: assert property (p_fix_high) else $error("fix pin not high");
  property p_fix_low;
    @(posedge clk) disable iff (!rstn) ce && !trk |=> !fix_status_output;
  endproperty
  a_fix_low: assert property (p_fix_low) else $error("fix pin not low");
  property p_lf_after_cr;
    @(posedge clk) disable iff (!rstn) step && st == ST_CR |=> st == ST_LF;
  endproperty
  a_lf_after_cr: assert property (p_lf_after_cr) else $error("CR not followed by LF");
  property p_fixq;
    @(posedge clk) disable iff (!rstn)
      step && st == ST_FIELD && is_fixq && cidx == 4'd1 && !pos_ok |-> out_ch == FIXQ_INVALID;
  endproperty
  a_fixq: assert property (p_fixq) else $error("bad fix quality");
  property p_intro_first;
    @(posedge clk) disable iff (!rstn) !started |-> kind == NSU_INTRO;
  endproperty
  a_intro_first: assert property (p_intro_first) else $error("intro skipped");
  property p_epoch;
    @(posedge clk) disable iff (!rstn) ce && !pos_ok |=> !epoch_out;
  endproperty
  a_epoch: assert property (p_epoch) else $error("epoch without position");
  property p_hex_upper;
    @(posedge clk) disable iff (!rstn)
      st == ST_HEX |-> (out_ch inside {[8'h30:8'h39], [8'h41:8'h46]});
  endproperty
  a_hex_upper: assert property (p_hex_upper) else $error("checksum digit bad");
endmodule

//--- dv/nsu_host_rx.sv
// Serial receiver model standing in for the host computer
`timescale 1ns/100ps
module nsu_host_rx #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk,
  input wire logic txd,
  output logic got,
  output logic [7:0] rx_byte,
  output int frame_errs
);
  // ==========================================
  // Character receiver
  // Sampling mid-bit tolerates the 2-3 cycle start latency of the sender
  initial
  begin
    got = 1'b0;
    rx_byte = 8'h00;
    frame_errs = 0;
    forever
    begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk);
      if (txd !== 1'b0)
        frame_errs++;
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(posedge clk);
        rx_byte[i] = txd;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (txd !== 1'b1)
        frame_errs++;
      got = 1'b1;
      @(posedge clk);
      got = 1'b0;
    end
  end
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the navigation sentence serial output
`timescale 1ns/100ps
module tb_top;
  import nsu_pkg::*;
  // ==========================================
  // Signals and model state
  localparam int BLINK = 100;
  localparam int BITC = 4;
  localparam int FCH = 12;
  logic clk, rstn, ce, epoch_tick, any_tracked, fix_valid, fix_propagated;
  logic utc_ready, subframe_seen, field_req, txd, fix_status_output, epoch_out;
  logic time_refined, got;
  logic [7:0] min_cn0_dbhz, rx_byte;
  logic [FCH*8-1:0] field_text;
  logic [3:0] field_len, field_sel;
  int frame_errs, errors, samples_checked, n;
  string fstr[16];
  string cur, s;
  string sq[$];
  string kinds[8] = '{"GPGGA", "GPGSA", "GPGLL", "GPRMC", "GPVTG", "GPGSV", "PSLSP", "PSLSV"};
  int nf[8] = '{14, 8, 7, 11, 9, 7, 7, 7};

  nsu_top #(.BLINK_CYC(BLINK), .BIT_CYC(BITC), .FIELD_CHARS(FCH)) dut (.clk(clk), .rstn(rstn),
    .ce(ce), .epoch_tick(epoch_tick), .any_tracked(any_tracked), .fix_valid(fix_valid),
    .fix_propagated(fix_propagated), .min_cn0_dbhz(min_cn0_dbhz), .utc_ready(utc_ready),
    .subframe_seen(subframe_seen), .field_text(field_text), .field_len(field_len),
    .field_req(field_req), .field_sel(field_sel), .txd(txd),
    .fix_status_output(fix_status_output), .epoch_out(epoch_out), .time_refined(time_refined));
  nsu_host_rx #(.BIT_CYC(BITC)) host (.clk(clk), .txd(txd), .got(got), .rx_byte(rx_byte),
    .frame_errs(frame_errs));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Field text follows the selector at once, so it is valid well before sampling
  always @*
  begin
    field_text = '0;
    field_len = 4'(fstr[field_sel].len());
    for (int i = 0; i < fstr[field_sel].len(); i++)
      field_text[8*i+:8] = fstr[field_sel][i];
  end

  always @(posedge got)
  begin
    cur = $sformatf("%s%c", cur, rx_byte);
    if (rx_byte == CH_LF)
    begin
      sq.push_back(cur);
      cur = "";
    end
  end

  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [7:0] hc(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction

  function automatic string mk(input string body);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < body.len(); i++)
      x ^= body[i];
    return $sformatf("$%s*%c%c%c%c", body, hc(x[7:4]), hc(x[3:0]), CH_CR, CH_LF);
  endfunction

  function automatic string fld(input string t, input int k);
    string r;
    int c;
    r = "";
    c = 0;
    for (int i = 1; i < t.len() && t[i] != CH_STAR; i++)
      if (t[i] == CH_COMMA)
        c++;
      else if (c == k)
        r = {r, t.substr(i, i)};
    return r;
  endfunction

  function automatic string exp_s(input int i, input logic [7:0] q);
    string b;
    b = kinds[i];
    for (int k = 0; k < nf[i]; k++)
      if (i == 0 && k == 5)
        b = $sformatf("%s,%c", b, q);
      else
        b = {b, ",", fstr[k]};
    return mk(b);
  endfunction

  task automatic next_s(output string t);
    int w, p;
    w = 0;
    p = 0;
    while (sq.size() == 0 && w < 40000)
    begin
      @(posedge clk);
      w++;
    end
    check("sentence arrived", sq.size() > 0, 1);
    t = (sq.size() > 0) ? sq.pop_front() : "";
    while (p < t.len() && t[p] != CH_STAR)
      p++;
    check("sentence form", t == mk(t.substr(1, p - 1)), 1);
    check("sentence length", t.len() <= MAX_SENTENCE_CHARS, 1);
  endtask

  task automatic seek(input string k, input int c);
    int w;
    w = 0;
    while (c > 0 && w < 40)
    begin
      next_s(s);
      w++;
      if (fld(s, 0) == k)
        c--;
    end
  endtask

  task automatic epoch(input logic exp);
    @(posedge clk);
    epoch_tick <= 1'b1;
    repeat (6) @(posedge clk);
    check("epoch pin", epoch_out, exp);
    epoch_tick <= 1'b0;
    repeat (6) @(posedge clk);
    check("epoch pin low", epoch_out, 1'b0);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    errors = 0;
    samples_checked = 0;
    cur = "";
    ce = 1'b1;
    rstn = 1'b0;
    epoch_tick = 1'b0;
    any_tracked = 1'b1;
    fix_valid = 1'b1;
    fix_propagated = 1'b0;
    min_cn0_dbhz = 8'h1e;
    utc_ready = 1'b1;
    subframe_seen = 1'b1;
    void'($urandom(32'he4222175));
    // Letters only, so no field can fake a separator or the star
    for (int k = 0; k < 16; k++)
    begin
      fstr[k] = $sformatf("%c", 8'h41 + $urandom % 26);
      if ($urandom % 2)
        fstr[k] = $sformatf("%s%c", fstr[k], 8'h41 + $urandom % 26);
    end
    repeat (8) @(posedge clk);
    check("idle line", txd, 1'b1);
    rstn <= 1'b1;
    next_s(s);
    check("intro", s == mk({"PSINI,", fstr[0]}), 1);
    for (int i = 0; i < 8; i++)
    begin
      next_s(s);
      check(kinds[i], s == exp_s(i, FIXQ_SAT), 1);
    end
    check("fix pin", fix_status_output, 1'b1);
    check("time refined", time_refined, 1'b1);
    epoch(1'b1);
    @(posedge clk);
    min_cn0_dbhz <= 8'h1d;
    utc_ready <= 1'b0;
    seek("GPGGA", 2);
    check("utc blank", fld(s, 1) == "", 1);
    check("lat blank", fld(s, 2) == "", 1);
    check("quality", fld(s, 6) == "0", 1);
    seek("PSLSP", 1);
    check("coarse time", fld(s, 1) != "", 1);
    n = 0;
    while (fix_status_output !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    while (fix_status_output !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (fix_status_output === 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check("blink high", n, BLINK);
    @(posedge clk);
    any_tracked <= 1'b0;
    fix_valid <= 1'b0;
    fix_propagated <= 1'b1;
    subframe_seen <= 1'b0;
    min_cn0_dbhz <= 8'h00;
    seek("GPGGA", 2);
    check("lost lat", fld(s, 2) == "", 1);
    check("quality lost", fld(s, 6) == "0", 1);
    check("fix pin none", fix_status_output, 1'b0);
    check("time cleared", time_refined, 1'b0);
    epoch(1'b0);
    // Reset lands in a stop bit, just after a line feed, so no character is cut
    next_s(s);
    rstn <= 1'b0;
    any_tracked <= 1'b1;
    fix_valid <= 1'b1;
    subframe_seen <= 1'b1;
    min_cn0_dbhz <= 8'(30 + $urandom % 200);
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    next_s(s);
    check("intro again", s == mk({"PSINI,", fstr[0]}), 1);
    seek("GPGGA", 1);
    check("utc blank fixed", fld(s, 1) == "", 1);
    check("lat with fix", fld(s, 2) == fstr[1], 1);
    check("quality prop", fld(s, 6) == "6", 1);
    check("fix pin prop", fix_status_output, 1'b1);
    check("framing", frame_errs, 0);
    tally_and_finish();
  end

  // A hang costs one mismatch and ends the run in the usual place
  initial
  begin
    repeat (80000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
endmodule
